/* File: include/rtcr_map.svh */
// Purpose: Offsets, codes and timing figures of the rate and mode control block
// Assumes: Included by bare name after the package
// Notes:   Timing figures are in microseconds at the system clock rate below
`ifndef RTCR_MAP_SVH
`define RTCR_MAP_SVH

// Register offsets on the multiplexed bus
`define RTCR_OFS_RATE     8'h0a
`define RTCR_OFS_MODE     8'h0b
`define RTCR_OFS_FLAG     8'h0c

// Power-on values of the control registers
`define RTCR_RATE_POR     7'h00
`define RTCR_MODE_POR     8'h00

// Divider select codes
`define RTCR_DIV_4M       3'h0
`define RTCR_DIV_1M       3'h1
`define RTCR_DIV_32K      3'h2
`define RTCR_DIV_HOLD     2'h3

// Divider step shifts, one second equals a full 22-bit wrap
`define RTCR_SHIFT_4M     5'h00
`define RTCR_SHIFT_1M     5'h02
`define RTCR_SHIFT_32K    5'h07
`define RTCR_DIV_HALF     22'h20_0000

// Rate tap placement
`define RTCR_RATE_OFF     4'h0
`define RTCR_TAP_BASE     5'h05
`define RTCR_TAP_SLOW     5'h0c
`define RTCR_RATE_SLOW    4'h3

// Alarm don't-care code in the two top bits
`define RTCR_ALARM_ANY    2'h3

// Timing
`define RTCR_CLK_MHZ      250
`define RTCR_T_BUC_US     244
`define RTCR_T_UC_FAST_US 248
`define RTCR_T_UC_SLOW_US 1984

`endif

/* File: include/rtcr_pkg.sv */
// Purpose: Types shared by the rate and mode control block
// Assumes: Nothing
// Notes:   Struct layouts follow the register bit order, MSB first
package rtcr_pkg;

    typedef struct packed {
        logic       update_pending_flag;
        logic [2:0] divider_select;
        logic [3:0] rate_select;
    } rtcr_rate_t;

    typedef struct packed {
        logic update_freeze;
        logic periodic_int_enable;
        logic alarm_int_enable;
        logic update_done_int_enable;
        logic square_wave_enable;
        logic binary_format_select;
        logic hour_24_select;
        logic daylight_saving_enable;
    } rtcr_mode_t;

    typedef struct packed {
        logic       summary_int_flag;
        logic       periodic_event_flag;
        logic       alarm_match_flag;
        logic       update_done_flag;
        logic [3:0] unused;
    } rtcr_flag_t;

    typedef struct packed {
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } rtcr_time_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PENDING,
        ST_UPDATE
    } rtcr_upd_t;

endpackage

/* File: rtl/rtcr_divider.sv */
// Purpose: Time-base sampling, 22-stage divider chain and rate tap
// Assumes: Time base well below half the system clock
// Notes:   Counter steps so that a full wrap is always one second
`timescale 1ns/100ps
`include "rtcr_map.svh"
module rtcr_divider
    import rtcr_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_time_base_in,
    input  wire logic [2:0] i_divider_select,
    input  wire logic [3:0] i_rate_select,
    output logic            o_second_tick,
    output logic            o_slow_base,
    output logic            o_tap_level,
    output logic            o_tap_fall
);
    logic        tb_s1_reg;
    logic        tb_s2_reg;
    logic        tb_prev_reg;
    logic        tb_edge;
    logic [21:0] cnt_reg;
    logic [22:0] cnt_next;
    logic [4:0]  shift;
    logic        stopped;
    logic        hold;
    logic [4:0]  tap_idx;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tb_s1_reg   <= 1'b0;
            tb_s2_reg   <= 1'b0;
            tb_prev_reg <= 1'b0;
        end else begin
            tb_s1_reg   <= i_time_base_in;
            tb_s2_reg   <= tb_s1_reg;
            tb_prev_reg <= tb_s2_reg;
        end
    end

    assign tb_edge     = tb_s2_reg & ~tb_prev_reg;
    assign hold        = (i_divider_select[2:1] == `RTCR_DIV_HOLD);
    assign o_slow_base = (i_divider_select == `RTCR_DIV_32K);

    always_comb begin
        stopped = 1'b0;
        shift   = `RTCR_SHIFT_4M;
        unique case (i_divider_select)
            `RTCR_DIV_4M:  shift = `RTCR_SHIFT_4M;
            `RTCR_DIV_1M:  shift = `RTCR_SHIFT_1M;
            `RTCR_DIV_32K: shift = `RTCR_SHIFT_32K;
            default:       stopped = 1'b1;
        endcase
    end

    assign cnt_next = {1'b0, cnt_reg} + {1'b0, 22'h00_0001 << shift};

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg       <= 22'h00_0000;
            o_second_tick <= 1'b0;
        end else begin
            o_second_tick <= 1'b0;
            if (hold) begin
                cnt_reg <= `RTCR_DIV_HALF;
            end else if (tb_edge && !stopped) begin
                cnt_reg       <= cnt_next[21:0];
                o_second_tick <= cnt_next[22];
            end
        end
    end

    // Slow base reuses the slow taps for codes 1 and 2
    always_comb begin
        if (o_slow_base && i_rate_select < `RTCR_RATE_SLOW) begin
            tap_idx = `RTCR_TAP_SLOW + {1'b0, i_rate_select};
        end else begin
            tap_idx = `RTCR_TAP_BASE + {1'b0, i_rate_select};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tap_level <= 1'b0;
            o_tap_fall  <= 1'b0;
        end else begin
            o_tap_level <= (i_rate_select != `RTCR_RATE_OFF) & cnt_reg[tap_idx];
            o_tap_fall  <= o_tap_level & ~((i_rate_select != `RTCR_RATE_OFF)
                           & cnt_reg[tap_idx]);
        end
    end

endmodule

/* File: rtl/rtcr_top.sv */
// Purpose: Rate and mode control registers with update cycle sequencing
// Assumes: Bus and reset pins are asynchronous; calendar logic lives outside
// Notes:   i_resetn is power-on only; the reset pin clears the interrupt and square-wave enables and the flags
`timescale 1ns/100ps
`include "rtcr_map.svh"
module rtcr_top
    import rtcr_pkg::*;
#(
    parameter int BUC_CYCLES     = `RTCR_T_BUC_US * `RTCR_CLK_MHZ,
    parameter int UC_FAST_CYCLES = `RTCR_T_UC_FAST_US * `RTCR_CLK_MHZ,
    parameter int UC_SLOW_CYCLES = `RTCR_T_UC_SLOW_US * `RTCR_CLK_MHZ
)
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_reset_pin_n,
    input  wire logic       i_time_base_in,
    input  wire logic [7:0] i_ad,
    output logic      [7:0] o_ad,
    output logic            o_ad_oe,
    input  wire logic       i_as,
    input  wire logic       i_ds,
    input  wire logic       i_rw,
    input  wire logic       i_cs_n,
    input  rtcr_time_t      i_time,
    input  rtcr_time_t      i_alarm,
    output logic            o_irq_n,
    output logic            o_square_wave_out,
    output logic            o_update_step,
    output logic            o_time_access,
    output logic            o_binary_format_select,
    output logic            o_hour_24_select,
    output logic            o_daylight_saving_enable
);
    logic [12:0] pin_s1_reg;
    logic [12:0] pin_s2_reg;
    logic [7:0]  ad_s;
    logic        as_s;
    logic        ds_s;
    logic        rw_s;
    logic        cs_n_s;
    logic        rst_pin_n_s;
    logic        as_prev_reg;
    logic        ds_prev_reg;
    logic [7:0]  addr_reg;
    logic        ds_fall;
    logic        wr_rate;
    logic        wr_mode;
    logic        rd_flag;
    logic        rd_hit;

    logic [2:0]  divider_select_reg;
    logic [3:0]  rate_select_reg;
    rtcr_mode_t  mode_reg;
    logic        update_freeze_reg;
    logic        periodic_int_enable_reg;
    logic        alarm_int_enable_reg;
    logic        update_done_int_enable_reg;
    logic        square_wave_enable_reg;
    logic        binary_format_select_reg;
    logic        hour_24_select_reg;
    logic        daylight_saving_enable_reg;
    rtcr_mode_t  wr_data;
    rtcr_rate_t  rate_view;
    rtcr_flag_t  flag_view;

    rtcr_upd_t   state_reg;
    logic [19:0] timer_reg;
    logic        step_d_reg;
    logic        alarm_hit;
    logic [2:0]  byte_hit;

    logic        periodic_event_flag_reg;
    logic        alarm_match_flag_reg;
    logic        update_done_flag_reg;
    logic        summary_int_flag;

    logic        second_tick;
    logic        slow_base;
    logic        tap_level;
    logic        tap_fall;

    rtcr_divider u_divider (
        .i_sys_clk        (i_sys_clk),
        .i_resetn         (i_resetn),
        .i_time_base_in   (i_time_base_in),
        .i_divider_select (divider_select_reg),
        .i_rate_select    (rate_select_reg),
        .o_second_tick    (second_tick),
        .o_slow_base      (slow_base),
        .o_tap_level      (tap_level),
        .o_tap_fall       (tap_fall)
    );

    // Pin synchronisers
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_s1_reg <= 13'h0000;
            pin_s2_reg <= 13'h0000;
        end else begin
            pin_s1_reg <= {i_reset_pin_n, i_cs_n, i_rw, i_ds, i_as, i_ad};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign ad_s        = pin_s2_reg[7:0];
    assign as_s        = pin_s2_reg[8];
    assign ds_s        = pin_s2_reg[9];
    assign rw_s        = pin_s2_reg[10];
    assign cs_n_s      = pin_s2_reg[11];
    assign rst_pin_n_s = pin_s2_reg[12];

    // Address latch on the falling address strobe
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            as_prev_reg <= 1'b0;
            ds_prev_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            as_prev_reg <= as_s;
            ds_prev_reg <= ds_s;
            if (as_prev_reg && !as_s) begin
                addr_reg <= ad_s;
            end
        end
    end

    assign ds_fall = ds_prev_reg & ~ds_s & ~cs_n_s;
    assign wr_rate = ds_fall & ~rw_s & (addr_reg == `RTCR_OFS_RATE);
    assign wr_mode = ds_fall & ~rw_s & (addr_reg == `RTCR_OFS_MODE);
    assign rd_flag = ds_fall & rw_s & (addr_reg == `RTCR_OFS_FLAG);
    assign rd_hit  = (addr_reg == `RTCR_OFS_RATE) | (addr_reg == `RTCR_OFS_MODE)
                   | (addr_reg == `RTCR_OFS_FLAG);
    assign wr_data = rtcr_mode_t'(ad_s);

    // Divider and rate fields answer only to writes
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {divider_select_reg, rate_select_reg} <= `RTCR_RATE_POR;
        end else if (wr_rate) begin
            divider_select_reg <= ad_s[6:4];
            rate_select_reg    <= ad_s[3:0];
        end
    end

    // Bits that only a write changes
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            update_freeze_reg          <= 1'b0;
            binary_format_select_reg   <= 1'b0;
            hour_24_select_reg         <= 1'b0;
            daylight_saving_enable_reg <= 1'b0;
        end else if (wr_mode) begin
            update_freeze_reg          <= wr_data.update_freeze;
            binary_format_select_reg   <= wr_data.binary_format_select;
            hour_24_select_reg         <= wr_data.hour_24_select;
            daylight_saving_enable_reg <= wr_data.daylight_saving_enable;
        end
    end

    // Enables cleared by the reset pin
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            periodic_int_enable_reg <= 1'b0;
            alarm_int_enable_reg    <= 1'b0;
            square_wave_enable_reg  <= 1'b0;
        end else if (!rst_pin_n_s) begin
            periodic_int_enable_reg <= 1'b0;
            alarm_int_enable_reg    <= 1'b0;
            square_wave_enable_reg  <= 1'b0;
        end else if (wr_mode) begin
            periodic_int_enable_reg <= wr_data.periodic_int_enable;
            alarm_int_enable_reg    <= wr_data.alarm_int_enable;
            square_wave_enable_reg  <= wr_data.square_wave_enable;
        end
    end

    // Update enable also drops when freeze rises
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            update_done_int_enable_reg <= 1'b0;
        end else if (!rst_pin_n_s) begin
            update_done_int_enable_reg <= 1'b0;
        end else if (wr_mode) begin
            if (wr_data.update_freeze && !mode_reg.update_freeze) begin
                update_done_int_enable_reg <= 1'b0;
            end else begin
                update_done_int_enable_reg <= wr_data.update_done_int_enable;
            end
        end
    end

    assign mode_reg = {update_freeze_reg, periodic_int_enable_reg, alarm_int_enable_reg,
                       update_done_int_enable_reg, square_wave_enable_reg,
                       binary_format_select_reg, hour_24_select_reg,
                       daylight_saving_enable_reg};

    // Update cycle sequencer, untouched by the reset pin
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg     <= ST_IDLE;
            timer_reg     <= 20'h0_0000;
            o_update_step <= 1'b0;
        end else begin
            o_update_step <= 1'b0;
            if (mode_reg.update_freeze) begin
                state_reg <= ST_IDLE;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                        if (second_tick) begin
                            state_reg <= ST_PENDING;
                            timer_reg <= 20'(BUC_CYCLES - 1);
                        end
                    end
                    ST_PENDING: begin
                        if (timer_reg == 20'h0_0000) begin
                            state_reg <= ST_UPDATE;
                            if (slow_base) begin
                                timer_reg <= 20'(UC_SLOW_CYCLES - 1);
                            end else begin
                                timer_reg <= 20'(UC_FAST_CYCLES - 1);
                            end
                        end else begin
                            timer_reg <= timer_reg - 20'h0_0001;
                        end
                    end
                    ST_UPDATE: begin
                        if (timer_reg == 20'h0_0000) begin
                            state_reg     <= ST_IDLE;
                            o_update_step <= 1'b1;
                        end else begin
                            timer_reg <= timer_reg - 20'h0_0001;
                        end
                    end
                endcase
            end
        end
    end

    // Time bytes leave the bus only during the update itself
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_time_access <= 1'b1;
        end else begin
            o_time_access <= !(state_reg == ST_UPDATE && !mode_reg.update_freeze);
        end
    end

    // Alarm compare one cycle after the step, per byte
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_alarm
            assign byte_hit[g] = (i_alarm[8*g+6 +: 2] == `RTCR_ALARM_ANY)
                               | (i_alarm[8*g +: 8] == i_time[8*g +: 8]);
        end
    endgenerate

    assign alarm_hit = &byte_hit;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            step_d_reg <= 1'b0;
        end else begin
            step_d_reg <= o_update_step;
        end
    end

    // Flags: hardware set wins over a flag-register read
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            periodic_event_flag_reg <= 1'b0;
            alarm_match_flag_reg    <= 1'b0;
            update_done_flag_reg    <= 1'b0;
        end else if (!rst_pin_n_s) begin
            periodic_event_flag_reg <= 1'b0;
            alarm_match_flag_reg    <= 1'b0;
            update_done_flag_reg    <= 1'b0;
        end else begin
            if (tap_fall) begin
                periodic_event_flag_reg <= 1'b1;
            end else if (rd_flag) begin
                periodic_event_flag_reg <= 1'b0;
            end
            if (step_d_reg && alarm_hit) begin
                alarm_match_flag_reg <= 1'b1;
            end else if (rd_flag) begin
                alarm_match_flag_reg <= 1'b0;
            end
            if (o_update_step) begin
                update_done_flag_reg <= 1'b1;
            end else if (rd_flag) begin
                update_done_flag_reg <= 1'b0;
            end
        end
    end

    assign summary_int_flag =
        (periodic_event_flag_reg & mode_reg.periodic_int_enable)
        | (alarm_match_flag_reg & mode_reg.alarm_int_enable)
        | (update_done_flag_reg & mode_reg.update_done_int_enable);

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq_n           <= 1'b1;
            o_square_wave_out <= 1'b0;
        end else begin
            o_irq_n           <= ~summary_int_flag;
            o_square_wave_out <= mode_reg.square_wave_enable & tap_level;
        end
    end

    // Read views
    assign rate_view.update_pending_flag = (state_reg != ST_IDLE);
    assign rate_view.divider_select      = divider_select_reg;
    assign rate_view.rate_select         = rate_select_reg;

    assign flag_view.summary_int_flag    = summary_int_flag;
    assign flag_view.periodic_event_flag = periodic_event_flag_reg;
    assign flag_view.alarm_match_flag    = alarm_match_flag_reg;
    assign flag_view.update_done_flag    = update_done_flag_reg;
    assign flag_view.unused              = 4'h0;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ad <= 8'h00;
        end else begin
            unique case (addr_reg)
                `RTCR_OFS_RATE: o_ad <= rate_view;
                `RTCR_OFS_MODE: o_ad <= mode_reg;
                `RTCR_OFS_FLAG: o_ad <= flag_view;
                default:        o_ad <= 8'h00;
            endcase
        end
    end

    assign o_ad_oe = ds_s & rw_s & ~cs_n_s & rd_hit;

    assign o_binary_format_select   = mode_reg.binary_format_select;
    assign o_hour_24_select         = mode_reg.hour_24_select;
    assign o_daylight_saving_enable = mode_reg.daylight_saving_enable;

endmodule

/* File: bench/rtcr_asserts.sv */
// Purpose: Port checks of the rate and mode control block
// Assumes: Update phase lengths come in as parameters
// Notes:   Bound to rtcr_top below
`timescale 1ns/100ps
module rtcr_asserts
    import rtcr_pkg::*;
#(
    parameter int UC_FAST_CYCLES = 62000,
    parameter int UC_SLOW_CYCLES = 496000
)
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_reset_pin_n,
    input wire logic o_irq_n,
    input wire logic o_square_wave_out,
    input wire logic o_update_step,
    input wire logic o_time_access,
    input wire logic o_binary_format_select,
    input wire logic o_hour_24_select
);
    logic [31:0] low_cnt_reg;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // Length of the current update phase
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) low_cnt_reg <= '0;
        else if (o_time_access) low_cnt_reg <= '0;
        else low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
    end
    uc_length_a: assert property ($rose(o_time_access) && $past(o_update_step) |->
        low_cnt_reg inside {[UC_FAST_CYCLES-1:UC_FAST_CYCLES+1],
        [UC_SLOW_CYCLES-1:UC_SLOW_CYCLES+1]})
        else $error("update phase length wrong");
    step_pulse_a: assert property (o_update_step |=> !o_update_step)
        else $error("update step longer than one cycle");
    step_end_a: assert property (o_update_step |-> !$past(o_time_access, 2))
        else $error("update step without update phase");
    access_after_a: assert property (o_update_step |=> o_time_access[*8])
        else $error("time bytes blocked after update");
    irq_rst_a: assert property ((!i_reset_pin_n)[*4] |=> o_irq_n)
        else $error("interrupt pin low under reset pin");
    sqw_rst_a: assert property ((!i_reset_pin_n)[*4] |=> !o_square_wave_out)
        else $error("square wave running under reset pin");
    dm_keep_a: assert property ((!i_reset_pin_n)[*2] |=> $stable(o_binary_format_select))
        else $error("data mode moved by reset pin");
    hour_keep_a: assert property ((!i_reset_pin_n)[*2] |=> $stable(o_hour_24_select))
        else $error("hour format moved by reset pin");
    cover property (o_update_step);
    cover property ($fell(o_irq_n));
    cover property ($rose(o_square_wave_out));
endmodule

bind rtcr_top rtcr_asserts #(
    .UC_FAST_CYCLES(UC_FAST_CYCLES),
    .UC_SLOW_CYCLES(UC_SLOW_CYCLES)
) i_chk (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reset_pin_n(i_reset_pin_n),
    .o_irq_n(o_irq_n), .o_square_wave_out(o_square_wave_out),
    .o_update_step(o_update_step), .o_time_access(o_time_access),
    .o_binary_format_select(o_binary_format_select), .o_hour_24_select(o_hour_24_select)
);

/* File: bench/rtcr_host.sv */
// Purpose: Processor on the multiplexed address and data bus
// Assumes: Pins change at the falling clock edge
// Notes:   Released bus lines show the inverse of the last value
`timescale 1ns/100ps
module rtcr_host
    import rtcr_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_bus,
    output logic      [7:0] o_ad,
    output logic            o_as,
    output logic            o_ds,
    output logic            o_rw,
    output logic            o_cs_n,
    output logic            o_rd_stb,
    output logic      [7:0] o_rd_val
);
    initial begin
        o_ad = 8'h00;
        o_as = 1'b0;
        o_ds = 1'b0;
        o_rw = 1'b1;
        o_cs_n = 1'b1;
        o_rd_stb = 1'b0;
        o_rd_val = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Address phase, then data phase; every strobe level held three cycles or more
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd);
        @(negedge i_clk);
        o_ad = a;
        o_as = 1'b1;
        hold(3);
        o_as = 1'b0;
        hold(3);
        o_ad = rd ? ~a : d;
        o_rw = rd;
        o_cs_n = 1'b0;
        o_ds = 1'b1;
        hold(5);
        o_rd_val = i_bus;
        o_rd_stb = rd;
        o_ds = 1'b0;
        hold(1);
        o_rd_stb = 1'b0;
        hold(2);
        o_cs_n = 1'b1;
        o_rw = 1'b1;
        o_ad = ~o_ad;
        hold(1);
    endtask
endmodule

/* File: bench/rtcr_top_tb.sv */
// Purpose: Self-checking bench of the rate and mode control block
// Assumes: Short update timing parameters
// Notes:   Read results are checked against a queue of expectations
`timescale 1ns/100ps
module rtcr_top_tb
    import rtcr_pkg::*;
;
    logic        i_sys_clk;
    logic        i_resetn;
    logic        i_reset_pin_n;
    logic        i_time_base_in;
    logic        dm_w, h24_w, dse_w;
    logic [7:0]  o_ad, host_ad, bus_ad, rd_val;
    logic        o_ad_oe, as_w, ds_w, rw_w, cs_n_w, rd_stb, o_irq_n, square_wave_out, step, p;
    rtcr_time_t  time_w, alarm_w;
    logic [7:0]  exp_q[$];
    int          bad_count, check_count, cyc, n;
    logic [31:0] seed;

    assign bus_ad = o_ad_oe ? o_ad : host_ad;
    rtcr_top #(.BUC_CYCLES(8), .UC_FAST_CYCLES(10), .UC_SLOW_CYCLES(20)) i_dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reset_pin_n(i_reset_pin_n),
        .i_time_base_in(i_time_base_in), .i_ad(bus_ad), .o_ad(o_ad), .o_ad_oe(o_ad_oe),
        .i_as(as_w), .i_ds(ds_w), .i_rw(rw_w), .i_cs_n(cs_n_w), .i_time(time_w),
        .i_alarm(alarm_w), .o_irq_n(o_irq_n), .o_square_wave_out(square_wave_out),
        .o_update_step(step), .o_time_access(), .o_binary_format_select(dm_w),
        .o_hour_24_select(h24_w), .o_daylight_saving_enable(dse_w));
    rtcr_host i_host (.i_clk(i_sys_clk), .i_bus(bus_ad), .o_ad(host_ad), .o_as(as_w),
        .o_ds(ds_w), .o_rw(rw_w), .o_cs_n(cs_n_w), .o_rd_stb(rd_stb), .o_rd_val(rd_val));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic idle(input int k);
        repeat (k) @(negedge i_sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(a, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.xfer(a, 8'h00, 1'b1);
    endtask
    task automatic rises(input int len);
        n = 0;
        for (int k = 0; k < len; k++) begin
            p = square_wave_out;
            idle(1);
            if (!p && square_wave_out) n++;
        end
    endtask

    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        i_time_base_in = 1'b0;
        forever begin
            idle(2);
            i_time_base_in = ~i_time_base_in;
        end
    end
    // Read results against the oldest expectation
    always @(posedge i_sys_clk) if (rd_stb) check(rd_val, exp_q.pop_front());
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        seed = 32'ha694;
        i_resetn = 1'b0;
        i_reset_pin_n = 1'b1;
        time_w = '0;
        alarm_w = 24'hc0_c0c0;
        idle(10);
        i_resetn = 1'b1;
        idle(4);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            time_w = seed[23:0];
            wr(8'h0a, seed[7:0]);
            rd(8'h0a, {1'b0, seed[6:0]});
            wr(8'h0b, {1'b0, seed[14:8]});
            rd(8'h0b, {1'b0, seed[14:8]});
        end
        wr(8'h0b, 8'h7f);
        wr(8'h0a, 8'h65);
        idle(2);
        i_reset_pin_n = 1'b0;
        idle(6);
        i_reset_pin_n = 1'b1;
        idle(4);
        rd(8'h0b, 8'h07);
        check({5'h00, dm_w, h24_w, dse_w}, 8'h07);
        rd(8'h0a, 8'h65);
        wr(8'h0b, 8'h90);
        rd(8'h0a, 8'h65);
        rd(8'h0b, 8'h80);
        // Periodic flag with its enable off, then on
        wr(8'h0a, 8'h21);
        wr(8'h0b, 8'h00);
        idle(1200);
        rd(8'h0c, 8'h40);
        wr(8'h0b, 8'h48);
        n = 0;
        while (o_irq_n !== 1'b0 && n < 600) begin
            idle(1);
            n++;
        end
        check({7'h00, o_irq_n}, 8'h00);
        rd(8'h0c, 8'hc0);
        idle(3);
        check({7'h00, o_irq_n}, 8'h01);
        rises(1024);
        check(n[7:0], 8'h02);
        wr(8'h0b, 8'h00);
        idle(4);
        rises(600);
        check({7'h00, square_wave_out} | n[7:0], 8'h00);
        // Divider hold, release, first update half a second later
        wr(8'h0b, 8'h30);
        wr(8'h0a, 8'h61);
        wr(8'h0a, 8'h21);
        n = 0;
        while (step !== 1'b1 && n < 80000) begin
            idle(1);
            n++;
        end
        check({7'h00, n >= 65530 && n <= 65660}, 8'h01);
        idle(6);
        check({7'h00, o_irq_n}, 8'h00);
        rd(8'h0c, 8'hf0);
        report_and_stop();
    end
endmodule
